// *** aeds_axis.sv ***
// Axis error detection, error code latch and stop handling
`timescale 1ns/1ps
`default_nettype none
`include "aeds_defines.svh"

module aeds_axis import aeds_pkg::*; #(
  parameter int POS_W = 32,
  parameter int SPD_W = 16,
  parameter logic [POS_W-1:0] POS_MAX = `AEDS_POS_MAX,
  parameter logic [SPD_W-1:0] SPD_MAX = `AEDS_SPD_MAX
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic host_controller_ready,
  input wire logic start_req,
  input wire logic start_home,
  input wire logic [POS_W-1:0] start_pos,
  input wire logic [SPD_W-1:0] start_speed,
  input wire logic [POS_W-1:0] param_pos,
  input wire logic [SPD_W-1:0] param_speed,
  input wire logic drive_ready,
  input wire logic limit_upper,
  input wire logic limit_lower,
  input wire logic stop_in,
  input wire logic op_stop_req,
  input wire logic rapid_stop_sel,
  input wire logic test_mode,
  input wire logic test_err,
  input wire logic at_home,
  input wire logic home_retry_en,
  input wire logic home_decel,
  input wire logic dog_detect,
  input wire logic [3:0] hw_fault,
  input wire logic axis_err_reset,
  output logic module_prep_done_flag,
  output logic busy,
  output logic system_halt,
  output logic test_lock,
  output logic [`AEDS_CODE_W-1:0] error_code,
  output aeds_stop_e stop_type,
  output logic [SPD_W-1:0] cmd_speed
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  aeds_state_e state_ff, nxt_state;
  aeds_stop_e stop_ff, nxt_stop;
  logic [`AEDS_CODE_W-1:0] code_ff;
  logic prep_ff, rdy_q_ff, ignore_ff, lock_ff, busy_ff, halt_ff;
  logic rdy_rise, rdy_fall, err_evt, load, ramp_stopped;
  logic [`AEDS_CODE_W-1:0] err_val;
  aeds_stop_e sel_stop;

  function automatic logic pos_ok(input logic [POS_W-1:0] v);
    return v <= POS_MAX;
  endfunction

  function automatic logic spd_ok(input logic [SPD_W-1:0] v);
    return (v != '0) && (v <= SPD_MAX);
  endfunction

  assign rdy_rise = host_controller_ready && !rdy_q_ff;
  assign rdy_fall = !host_controller_ready && rdy_q_ff;
  assign sel_stop = rapid_stop_sel ? AEDS_ST_RAPID : AEDS_ST_DECEL;

  // ----------------------------------------------------------------
  // Error detection and sequencing
  // ----------------------------------------------------------------
  always_comb begin
    nxt_state = state_ff;
    nxt_stop = stop_ff;
    err_evt = 1'b0;
    err_val = `AEDS_ERR_NONE;
    load = 1'b0;
    case (state_ff)
      AEDS_IDLE: begin
        if (rdy_rise && !pos_ok(param_pos)) begin
          err_evt = 1'b1;
          err_val = `AEDS_ERR_POS_RANGE;
        end else if (rdy_rise && !spd_ok(param_speed)) begin
          err_evt = 1'b1;
          err_val = `AEDS_ERR_SPD_RANGE;
        end else if (start_req && host_controller_ready && !ignore_ff && !lock_ff) begin
          err_evt = 1'b1;
          if (limit_upper) begin
            err_val = `AEDS_ERR_LIM_UP;
          end else if (limit_lower) begin
            err_val = `AEDS_ERR_LIM_LO;
          end else if (stop_in) begin
            err_val = `AEDS_ERR_STOP_IN;
          end else if (start_home && at_home && !home_retry_en) begin
            err_val = `AEDS_ERR_AT_HOME;
          end else if (!start_home && !pos_ok(start_pos)) begin
            err_val = `AEDS_ERR_POS_RANGE;
          end else if (!spd_ok(start_speed)) begin
            err_val = `AEDS_ERR_SPD_RANGE;
          end else begin
            err_evt = 1'b0;
            load = 1'b1;
            nxt_state = AEDS_RUN;
            nxt_stop = AEDS_ST_NONE;
          end
        end
      end
      AEDS_RUN: begin
        err_evt = 1'b1;
        nxt_state = AEDS_STOP;
        if (!drive_ready) begin
          err_val = `AEDS_ERR_DRV_OFF;
          nxt_stop = AEDS_ST_IMMED;
        end else if (limit_upper) begin
          err_val = `AEDS_ERR_LIM_UP;
          nxt_stop = AEDS_ST_DECEL;
        end else if (limit_lower) begin
          err_val = `AEDS_ERR_LIM_LO;
          nxt_stop = AEDS_ST_DECEL;
        end else if (test_mode && test_err) begin
          err_val = `AEDS_ERR_TEST;
          nxt_stop = AEDS_ST_DECEL;
        end else if (!host_controller_ready) begin
          err_val = `AEDS_ERR_HOST_OFF;
          nxt_stop = sel_stop;
        end else if (op_stop_req) begin
          err_val = `AEDS_ERR_OP_STOP;
          nxt_stop = sel_stop;
        end else if (home_decel && dog_detect) begin
          err_val = `AEDS_ERR_DOG;
          nxt_stop = AEDS_ST_DECEL;
        end else if (rdy_rise) begin
          err_val = `AEDS_ERR_RDY_BUSY;
          nxt_state = AEDS_RUN;
        end else begin
          err_evt = 1'b0;
          nxt_state = AEDS_RUN;
        end
      end
      AEDS_STOP: begin
        if (rdy_rise) begin
          err_evt = 1'b1;
          err_val = `AEDS_ERR_RDY_BUSY;
        end
        if (ramp_stopped) begin
          nxt_state = AEDS_IDLE;
        end
      end
      AEDS_HALT: nxt_state = AEDS_HALT;
      default: nxt_state = AEDS_IDLE;
    endcase
    // Hardware faults outrank every axis condition
    if (state_ff != AEDS_HALT && hw_fault != 4'h0) begin
      err_evt = 1'b1;
      nxt_state = AEDS_HALT;
      nxt_stop = AEDS_ST_IMMED;
      if (hw_fault[`AEDS_FLT_FAULT]) begin
        err_val = `AEDS_ERR_FAULT;
      end else if (hw_fault[`AEDS_FLT_ZERO]) begin
        err_val = `AEDS_ERR_ZERO;
      end else if (hw_fault[`AEDS_FLT_OVFL]) begin
        err_val = `AEDS_ERR_OVFL;
      end else begin
        err_val = `AEDS_ERR_UNFL;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_ff <= AEDS_IDLE;
      stop_ff <= AEDS_ST_NONE;
      busy_ff <= 1'b0;
      halt_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      stop_ff <= nxt_stop;
      busy_ff <= (nxt_state == AEDS_RUN) || (nxt_state == AEDS_STOP);
      halt_ff <= (nxt_state == AEDS_HALT);
    end
  end

  // ----------------------------------------------------------------
  // Error code latch; a new error wins over a reset in the same cycle
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      code_ff <= `AEDS_ERR_NONE;
    end else if (err_evt) begin
      code_ff <= err_val;
    end else if (axis_err_reset && !halt_ff && !lock_ff) begin
      code_ff <= `AEDS_ERR_NONE;
    end
  end

  // Only a power cycle, seen here as reset, releases the test lock
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      lock_ff <= 1'b0;
    end else if (err_evt && err_val == `AEDS_ERR_TEST) begin
      lock_ff <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Host ready tracking and preparation flag
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      rdy_q_ff <= 1'b0;
      prep_ff <= `AEDS_PREP_RST;
      ignore_ff <= 1'b0;
    end else begin
      rdy_q_ff <= host_controller_ready;
      if (rdy_fall) begin
        prep_ff <= 1'b1;
        ignore_ff <= 1'b0;
      end else if (rdy_rise && busy_ff) begin
        ignore_ff <= 1'b1;
      end else if (rdy_rise && !err_evt && state_ff == AEDS_IDLE) begin
        prep_ff <= 1'b0;
      end
    end
  end

  aeds_ramp #(
    .SPD_W(SPD_W)
  ) u_ramp (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .load(load),
    .load_speed(start_speed),
    .stopping(state_ff == AEDS_STOP || state_ff == AEDS_HALT),
    .stop_type(stop_ff),
    .speed_ff(cmd_speed),
    .stopped_ff(ramp_stopped)
  );

  assign module_prep_done_flag = prep_ff;
  assign busy = busy_ff;
  assign system_halt = halt_ff;
  assign test_lock = lock_ff;
  assign error_code = code_ff;
  assign stop_type = stop_ff;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  wire run_q = (state_ff == AEDS_RUN) && hw_fault == 4'h0;
  wire idle_start = (state_ff == AEDS_IDLE) && hw_fault == 4'h0 && !rdy_rise && start_req
    && host_controller_ready && !ignore_ff && !lock_ff;

  property p_pos_rise;
    @(posedge sys_clk) disable iff (!reset_n)
    (state_ff == AEDS_IDLE) && hw_fault == 4'h0 && rdy_rise && !pos_ok(param_pos)
    |=> module_prep_done_flag && error_code == `AEDS_ERR_POS_RANGE;
  endproperty
  a_pos_rise: assert property (p_pos_rise) else $error("pos range rise");

  property p_spd_start;
    @(posedge sys_clk) disable iff (!reset_n)
    idle_start && !limit_upper && !limit_lower && !stop_in && !start_home
    && pos_ok(start_pos) && !spd_ok(start_speed)
    |=> !busy && error_code == `AEDS_ERR_SPD_RANGE;
  endproperty
  a_spd_start: assert property (p_spd_start) else $error("speed range start");

  property p_op_stop;
    @(posedge sys_clk) disable iff (!reset_n)
    run_q && drive_ready && !limit_upper && !limit_lower && !(test_mode && test_err)
    && host_controller_ready && op_stop_req
    |=> error_code == `AEDS_ERR_OP_STOP && stop_type != AEDS_ST_IMMED;
  endproperty
  a_op_stop: assert property (p_op_stop) else $error("operator stop");

  property p_host_off;
    @(posedge sys_clk) disable iff (!reset_n)
    run_q && drive_ready && !limit_upper && !limit_lower && !(test_mode && test_err)
    && !host_controller_ready
    |=> error_code == `AEDS_ERR_HOST_OFF && stop_type == $past(sel_stop);
  endproperty
  a_host_off: assert property (p_host_off) else $error("host ready off");

  property p_drv_off;
    @(posedge sys_clk) disable iff (!reset_n)
    run_q && !drive_ready |=> error_code == `AEDS_ERR_DRV_OFF && stop_type == AEDS_ST_IMMED
    ##1 cmd_speed == '0;
  endproperty
  a_drv_off: assert property (p_drv_off) else $error("drive off not immediate");

  property p_test;
    @(posedge sys_clk) disable iff (!reset_n)
    run_q && drive_ready && !limit_upper && !limit_lower && test_mode && test_err
    |=> test_lock && error_code == `AEDS_ERR_TEST ##1 test_lock;
  endproperty
  a_test: assert property (p_test) else $error("test error lock");

  property p_lim_start;
    @(posedge sys_clk) disable iff (!reset_n)
    idle_start && limit_upper |=> !busy && error_code == `AEDS_ERR_LIM_UP;
  endproperty
  a_lim_start: assert property (p_lim_start) else $error("upper limit start");

  property p_stop_in;
    @(posedge sys_clk) disable iff (!reset_n)
    idle_start && !limit_upper && !limit_lower && stop_in
    |=> !busy && error_code == `AEDS_ERR_STOP_IN;
  endproperty
  a_stop_in: assert property (p_stop_in) else $error("stop input start");

  property p_rdy_busy;
    @(posedge sys_clk) disable iff (!reset_n)
    busy && rdy_rise |=> ignore_ff && module_prep_done_flag;
  endproperty
  a_rdy_busy: assert property (p_rdy_busy) else $error("ready rise while busy");

  property p_home;
    @(posedge sys_clk) disable iff (!reset_n)
    idle_start && !limit_upper && !limit_lower && !stop_in && start_home && at_home
    && !home_retry_en |=> !busy && error_code == `AEDS_ERR_AT_HOME;
  endproperty
  a_home: assert property (p_home) else $error("start at home");

  property p_dog;
    @(posedge sys_clk) disable iff (!reset_n)
    run_q && drive_ready && !limit_upper && !limit_lower && !(test_mode && test_err)
    && host_controller_ready && !op_stop_req && home_decel && dog_detect
    |=> error_code == `AEDS_ERR_DOG && stop_type == AEDS_ST_DECEL;
  endproperty
  a_dog: assert property (p_dog) else $error("dog timing");

  property p_fault;
    @(posedge sys_clk) disable iff (!reset_n)
    !system_halt && hw_fault[`AEDS_FLT_FAULT] |=> system_halt
    && error_code == `AEDS_ERR_FAULT ##1 system_halt;
  endproperty
  a_fault: assert property (p_fault) else $error("fault halt");

  property p_clear;
    @(posedge sys_clk) disable iff (!reset_n)
    axis_err_reset && !err_evt && !system_halt && !test_lock |=> error_code == `AEDS_ERR_NONE;
  endproperty
  a_clear: assert property (p_clear) else $error("error reset");

  property p_hold;
    @(posedge sys_clk) disable iff (!reset_n)
    !axis_err_reset && !err_evt |=> $stable(error_code);
  endproperty
  a_hold: assert property (p_hold) else $error("error code not held");

endmodule
`default_nettype wire

// *** aeds_defines.svh ***
// Constants for the axis error detect and stop block
`ifndef AEDS_DEFINES_SVH
`define AEDS_DEFINES_SVH

// ----------------------------------------------------------------
// Error codes (decimal code value held in binary)
// ----------------------------------------------------------------
`define AEDS_CODE_W 10
`define AEDS_ERR_NONE 10'h000
`define AEDS_ERR_FAULT 10'h001
`define AEDS_ERR_ZERO 10'h003
`define AEDS_ERR_OVFL 10'h004
`define AEDS_ERR_UNFL 10'h005
`define AEDS_ERR_POS_RANGE 10'h033
`define AEDS_ERR_SPD_RANGE 10'h034
`define AEDS_ERR_OP_STOP 10'h064
`define AEDS_ERR_HOST_OFF 10'h065
`define AEDS_ERR_DRV_OFF 10'h066
`define AEDS_ERR_TEST 10'h067
`define AEDS_ERR_LIM_UP 10'h068
`define AEDS_ERR_LIM_LO 10'h069
`define AEDS_ERR_STOP_IN 10'h06A
`define AEDS_ERR_RDY_BUSY 10'h06B
`define AEDS_ERR_AT_HOME 10'h0C9
`define AEDS_ERR_DOG 10'h0CB

// ----------------------------------------------------------------
// Fault input bit positions
// ----------------------------------------------------------------
`define AEDS_FLT_FAULT 0
`define AEDS_FLT_ZERO 1
`define AEDS_FLT_OVFL 2
`define AEDS_FLT_UNFL 3

// ----------------------------------------------------------------
// Reset values and default limits
// ----------------------------------------------------------------
`define AEDS_PREP_RST 1'b1
`define AEDS_POS_MAX 32'h3FFFFFFF
`define AEDS_SPD_MAX 16'hF000
`define AEDS_DECEL_STEP 16'h0001
`define AEDS_RAPID_STEP 16'h0010

`endif

// *** aeds_host_model.sv ***
// Host controller model: ready level, start pulses and axis error reset
`timescale 1ns/1ps
`default_nettype none

module aeds_host_model (
  input wire logic sys_clk,
  output logic host_controller_ready,
  output logic start_req,
  output logic start_home,
  output logic axis_err_reset
);
  initial begin
    host_controller_ready = 1'h1;
    start_req = 1'h0;
    start_home = 1'h0;
    axis_err_reset = 1'h0;
  end

  task automatic set_ready(input logic v);
    @(posedge sys_clk);
    host_controller_ready <= v;
  endtask

  // Off then on again; the only way out of an ignored start
  task automatic toggle_ready();
    set_ready(1'h0);
    repeat (2) @(posedge sys_clk);
    host_controller_ready <= 1'h1;
  endtask

  // One cycle pulse, held across the edge that samples it
  task automatic start(input logic home);
    @(posedge sys_clk);
    start_req <= 1'h1;
    start_home <= home;
    @(posedge sys_clk);
    start_req <= 1'h0;
  endtask

  task automatic err_reset();
    @(posedge sys_clk);
    axis_err_reset <= 1'h1;
    @(posedge sys_clk);
    axis_err_reset <= 1'h0;
  endtask
endmodule
`default_nettype wire

// *** aeds_pkg.sv ***
// Types for the axis error detect and stop block
package aeds_pkg;

  // Gray order along idle, run, stop, halt
  typedef enum logic [1:0] {
    AEDS_IDLE = 2'b00,
    AEDS_RUN  = 2'b01,
    AEDS_STOP = 2'b11,
    AEDS_HALT = 2'b10
  } aeds_state_e;

  typedef enum logic [1:0] {
    AEDS_ST_NONE  = 2'b00,
    AEDS_ST_DECEL = 2'b01,
    AEDS_ST_RAPID = 2'b11,
    AEDS_ST_IMMED = 2'b10
  } aeds_stop_e;

endpackage

// *** aeds_ramp.sv ***
// Speed ramp that winds the commanded speed down for each stop type
`timescale 1ns/1ps
`default_nettype none
`include "aeds_defines.svh"

module aeds_ramp import aeds_pkg::*; #(
  parameter int SPD_W = 16,
  parameter logic [SPD_W-1:0] DECEL_STEP = `AEDS_DECEL_STEP,
  parameter logic [SPD_W-1:0] RAPID_STEP = `AEDS_RAPID_STEP
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic load,
  input wire logic [SPD_W-1:0] load_speed,
  input wire logic stopping,
  input wire aeds_stop_e stop_type,
  output logic [SPD_W-1:0] speed_ff,
  output logic stopped_ff
);

  logic [SPD_W-1:0] nxt_speed;
  logic [SPD_W-1:0] step;

  // Saturating step keeps the ramp from wrapping past zero
  always_comb begin
    step = DECEL_STEP;
    nxt_speed = speed_ff;
    case (stop_type)
      AEDS_ST_RAPID: step = RAPID_STEP;
      default: step = DECEL_STEP;
    endcase
    if (load) begin
      nxt_speed = load_speed;
    end else if (stopping) begin
      if (stop_type == AEDS_ST_IMMED || speed_ff <= step) begin
        nxt_speed = '0;
      end else begin
        nxt_speed = speed_ff - step;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      speed_ff <= '0;
      stopped_ff <= 1'b1;
    end else begin
      speed_ff <= nxt_speed;
      stopped_ff <= (nxt_speed == '0);
    end
  end

endmodule
`default_nettype wire

// *** tb_top.sv ***
// Self-checking bench for the axis error detect and stop block
`timescale 1ns/1ps
`default_nettype none
`include "aeds_defines.svh"
`define CHK(n, e, g) begin \
  comparisons++; \
  if ((g) !== (e)) begin \
    miscompares++; \
    $display("[ERR] %s exp %0h got %0h", n, e, g); \
  end \
end

module tb_top import aeds_pkg::*; ();
  logic sys_clk, reset_n, hcr, sreq, shome, aer;
  logic [31:0] spos, ppos;
  logic [15:0] sspd, pspd, cmd;
  logic drdy, lup, llo, stp, ops, rsel, tm, terr, ath, hre, hdec, dog;
  logic [3:0] flt;
  logic prep, busy, halt, tlock;
  logic [9:0] code;
  aeds_stop_e stype;
  int miscompares, comparisons;

  aeds_axis DUT (.sys_clk(sys_clk), .reset_n(reset_n), .host_controller_ready(hcr),
    .start_req(sreq), .start_home(shome), .start_pos(spos), .start_speed(sspd),
    .param_pos(ppos), .param_speed(pspd), .drive_ready(drdy), .limit_upper(lup),
    .limit_lower(llo), .stop_in(stp), .op_stop_req(ops), .rapid_stop_sel(rsel),
    .test_mode(tm), .test_err(terr), .at_home(ath), .home_retry_en(hre),
    .home_decel(hdec), .dog_detect(dog), .hw_fault(flt), .axis_err_reset(aer),
    .module_prep_done_flag(prep), .busy(busy), .system_halt(halt), .test_lock(tlock),
    .error_code(code), .stop_type(stype), .cmd_speed(cmd));

  aeds_host_model HOST (.sys_clk(sys_clk), .host_controller_ready(hcr), .start_req(sreq),
    .start_home(shome), .axis_err_reset(aer));

  initial begin
    sys_clk = 1'h0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  task automatic tally_and_finish();
    $display("miscompares %0d comparisons %0d", miscompares, comparisons);
    if (miscompares == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  // Bounded wait for idle; a hang ends the run
  task automatic wait_idle();
    for (int i = 0; i < 300; i++) begin
      if (busy === 1'h0) return;
      cyc(1);
    end
    miscompares++;
    $display("[ERR] busy exp 0 got %0h", busy);
    tally_and_finish();
  endtask

  // Parameter limits sit on their boundary: accepted values
  task automatic set_good();
    @(posedge sys_clk);
    drdy <= 1'h1;
    lup <= 1'h0;
    llo <= 1'h0;
    stp <= 1'h0;
    ops <= 1'h0;
    rsel <= 1'h0;
    ath <= 1'h0;
    hre <= 1'h0;
    hdec <= 1'h0;
    dog <= 1'h0;
    spos <= 32'h00001000;
    sspd <= 16'h0040;
    ppos <= 32'h3FFFFFFF;
    pspd <= 16'hF000;
  endtask

  // Ready stays high through reset, so release reads as a clean rise
  task automatic do_reset();
    @(posedge sys_clk);
    reset_n <= 1'h0;
    flt <= 4'h0;
    tm <= 1'h0;
    terr <= 1'h0;
    cyc(10);
    `CHK("prep_rst", 1'h1, prep)
    `CHK("code_rst", 10'h000, code)
    @(posedge sys_clk);
    reset_n <= 1'h1;
    cyc(2);
    `CHK("prep_up", 1'h0, prep)
  endtask

  task automatic t_params();
    for (int j = 0; j < 2; j++) begin
      HOST.set_ready(1'h0);
      cyc(2);
      `CHK("prep_fall", 1'h1, prep)
      @(posedge sys_clk);
      if (j == 0) ppos <= 32'h40000000;
      else pspd <= 16'h0000;
      HOST.set_ready(1'h1);
      cyc(2);
      `CHK("code_rise", (j ? `AEDS_ERR_SPD_RANGE : `AEDS_ERR_POS_RANGE), code)
      `CHK("prep_keep", 1'h1, prep)
      set_good();
      HOST.err_reset();
      HOST.toggle_ready();
      cyc(2);
      `CHK("prep_clean", 1'h0, prep)
      `CHK("code_clr", 10'h000, code)
    end
    $display("test params done");
  endtask

  task automatic t_refuse();
    logic [9:0] ec [6] = '{`AEDS_ERR_LIM_UP, `AEDS_ERR_LIM_LO, `AEDS_ERR_STOP_IN,
      `AEDS_ERR_AT_HOME, `AEDS_ERR_POS_RANGE, `AEDS_ERR_SPD_RANGE};
    for (int i = 0; i < 6; i++) begin
      @(posedge sys_clk);
      lup <= (i == 0);
      llo <= (i == 1);
      stp <= (i == 2);
      ath <= (i == 3);
      if (i == 4) spos <= 32'h40000000;
      if (i == 5) sspd <= 16'h0000;
      HOST.start(i == 3);
      cyc(2);
      `CHK("busy_ref", 1'h0, busy)
      `CHK("code_ref", ec[i], code)
      set_good();
      HOST.err_reset();
      cyc(2);
      `CHK("code_clr", 10'h000, code)
    end
    // Retry enabled lets a home return start while already at home
    @(posedge sys_clk);
    ath <= 1'h1;
    hre <= 1'h1;
    HOST.start(1'h1);
    cyc(2);
    `CHK("home_retry", 1'h1, busy)
    @(posedge sys_clk);
    ops <= 1'h1;
    wait_idle();
    set_good();
    HOST.err_reset();
    cyc(2);
    `CHK("code_clr", 10'h000, code)
    $display("test refuse done");
  endtask

  task automatic t_stops();
    logic [9:0] ec [6] = '{`AEDS_ERR_DRV_OFF, `AEDS_ERR_LIM_UP, `AEDS_ERR_LIM_LO,
      `AEDS_ERR_HOST_OFF, `AEDS_ERR_OP_STOP, `AEDS_ERR_DOG};
    aeds_stop_e st [6] = '{AEDS_ST_IMMED, AEDS_ST_DECEL, AEDS_ST_DECEL, AEDS_ST_RAPID,
      AEDS_ST_DECEL, AEDS_ST_DECEL};
    logic [15:0] dec [6] = '{16'h0000, 16'h0001, 16'h0001, 16'h0010, 16'h0001, 16'h0001};
    logic [15:0] s3;
    for (int i = 0; i < 6; i++) begin
      HOST.start(i == 5);
      cyc(2);
      `CHK("run", 1'h1, busy)
      if (i == 3) HOST.set_ready(1'h0);
      else @(posedge sys_clk);
      drdy <= (i != 0);
      lup <= (i == 1);
      llo <= (i == 2);
      rsel <= (i == 3);
      ops <= (i == 4);
      hdec <= (i == 5);
      dog <= (i == 5);
      cyc(2);
      `CHK("code_stop", ec[i], code)
      `CHK("stop_type", st[i], stype)
      cyc(1);
      s3 = cmd;
      cyc(1);
      `CHK("ramp_step", dec[i], s3 - cmd)
      set_good();
      wait_idle();
      `CHK("cmd_idle", 16'h0000, cmd)
      `CHK("code_hold", ec[i], code)
      if (i == 3) HOST.set_ready(1'h1);
      HOST.err_reset();
      cyc(2);
      `CHK("code_clr", 10'h000, code)
    end
    $display("test stops done");
  endtask

  task automatic t_busy_rise();
    HOST.start(1'h0);
    cyc(2);
    HOST.set_ready(1'h0);
    cyc(2);
    HOST.set_ready(1'h1);
    cyc(2);
    `CHK("code_107", `AEDS_ERR_RDY_BUSY, code)
    `CHK("prep_107", 1'h1, prep)
    wait_idle();
    HOST.err_reset();
    HOST.start(1'h0);
    cyc(3);
    `CHK("start_ignored", 1'h0, busy)
    HOST.toggle_ready();
    cyc(2);
    HOST.start(1'h0);
    cyc(2);
    `CHK("start_again", 1'h1, busy)
    @(posedge sys_clk);
    ops <= 1'h1;
    wait_idle();
    set_good();
    HOST.err_reset();
    $display("test busy rise done");
  endtask

  task automatic t_test_err();
    HOST.start(1'h0);
    cyc(2);
    @(posedge sys_clk);
    tm <= 1'h1;
    terr <= 1'h1;
    cyc(2);
    `CHK("code_103", `AEDS_ERR_TEST, code)
    `CHK("type_103", AEDS_ST_DECEL, stype)
    wait_idle();
    `CHK("lock", 1'h1, tlock)
    HOST.err_reset();
    HOST.start(1'h0);
    cyc(2);
    `CHK("code_kept", `AEDS_ERR_TEST, code)
    `CHK("lock_nostart", 1'h0, busy)
    do_reset();
    `CHK("lock_clr", 1'h0, tlock)
    $display("test mode error done");
  endtask

  // Odd bits hit a running axis, even bits an idle one
  task automatic t_faults();
    logic [9:0] ec [4] = '{`AEDS_ERR_FAULT, `AEDS_ERR_ZERO, `AEDS_ERR_OVFL, `AEDS_ERR_UNFL};
    for (int b = 0; b < 4; b++) begin
      if (b % 2 == 1) HOST.start(1'h0);
      @(posedge sys_clk);
      flt[b] <= 1'h1;
      cyc(2);
      `CHK("halt", 1'h1, halt)
      `CHK("code_flt", ec[b], code)
      HOST.err_reset();
      HOST.start(1'h0);
      cyc(2);
      `CHK("code_flt_kept", ec[b], code)
      `CHK("halt_nostart", 1'h0, busy)
      do_reset();
    end
    $display("test faults done");
  endtask

  initial begin
    miscompares = 0;
    comparisons = 0;
    reset_n = 1'h0;
    drdy = 1'h1;
    lup = 1'h0;
    llo = 1'h0;
    stp = 1'h0;
    ops = 1'h0;
    rsel = 1'h0;
    tm = 1'h0;
    terr = 1'h0;
    ath = 1'h0;
    hre = 1'h0;
    hdec = 1'h0;
    dog = 1'h0;
    spos = 32'h00001000;
    ppos = 32'h3FFFFFFF;
    sspd = 16'h0040;
    pspd = 16'hF000;
    flt = 4'h0;
    do_reset();
    t_params();
    t_refuse();
    t_stops();
    t_busy_rise();
    t_test_err();
    t_faults();
    tally_and_finish();
  end
endmodule
`default_nettype wire
